// ===== ltos_pkg.sv
/*
  Shared constants for the link training block: symbol codes, training set
  layout, field bits, training counts and the one-hot training state type.
  Assumes one 8-bit symbol plus a control flag per lane per clock.
*/
`default_nettype none
package ltos_pkg;
  // ==========================================================
  // Symbol codes
  localparam logic [7:0] SYM_COM     = 8'hbc;
  localparam logic [7:0] SYM_PAD     = 8'hf7;
  localparam logic [7:0] SYM_SKP     = 8'h1c;
  localparam logic [7:0] ID_TS1      = 8'h4a;
  localparam logic [7:0] ID_TS1_INV  = 8'hb5;
  localparam logic [7:0] ID_TS2      = 8'h45;
  localparam logic [7:0] ID_TS2_INV  = 8'hba;
  localparam logic [7:0] LANE_MAX    = 8'h1f;
  localparam logic [7:0] SYM_ZERO    = 8'h00;
  // ==========================================================
  // Training set layout
  localparam logic [3:0] IDX_COM     = 4'h0;
  localparam logic [3:0] IDX_LINK    = 4'h1;
  localparam logic [3:0] IDX_LANE    = 4'h2;
  localparam logic [3:0] IDX_NFTS    = 4'h3;
  localparam logic [3:0] IDX_RATE    = 4'h4;
  localparam logic [3:0] IDX_CTRL    = 4'h5;
  localparam logic [3:0] IDX_ID      = 4'h6;
  localparam logic [3:0] IDX_LAST    = 4'hf;
  localparam int         TS_LEN      = 16;
  localparam logic [7:0] RATE_GEN1   = 8'h02;
  localparam logic [7:0] RATE_GEN2   = 8'h04;
  localparam int         RATE_UPCFG_BIT = 6;
  localparam int         CTRL_COMPL_BIT = 4;
  // ==========================================================
  // Training counts
  localparam logic [3:0] LOCK_SETS   = 4'h8;
  localparam logic [4:0] RX_NEED     = 5'h08;
  localparam logic [4:0] TX_NEED     = 5'h10;
  // ==========================================================
  // Training states
  typedef enum logic [3:0] {
    ST_DETECT = 4'b0001,
    ST_POLL   = 4'b0010,
    ST_CONFIG = 4'b0100,
    ST_L0     = 4'b1000
  } ltos_state_t;
endpackage
`default_nettype wire

// ===== ltos_lane_rx.sv
/*
  Per-lane receive parser: finds COM, walks the sixteen training symbols,
  classifies TS1/TS2, drops skip sets, tracks lock and lane polarity.
  Assumes symbols arrive unscrambled, one per clock, already 8b decoded.
*/
`timescale 1ns/1ps
`default_nettype none
module ltos_lane_rx (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_is_k,
  output logic            ts1_ok,
  output logic            ts2_ok,
  output logic            locked,
  output logic            rx_invert,
  output logic [7:0]      link_num,
  output logic            link_pad,
  output logic [7:0]      lane_num,
  output logic [7:0]      nfts,
  output logic [7:0]      rate,
  output logic            compl_rx,
  output logic            upcfg
);
  import ltos_pkg::*;

  typedef struct packed {
    logic [3:0] idx;
    logic       in_set;
    logic       bad;
    logic       is_ts2;
    logic       pol;
    logic [3:0] lock_cnt;
    logic       locked;
    logic [7:0] link;
    logic       link_pad;
    logic [7:0] lane;
    logic [7:0] nfts;
    logic [7:0] rate;
    logic [7:0] ctrl;
    logic       compl;
    logic       upcfg;
    logic       ts1_p;
    logic       ts2_p;
  } ltos_lrx_t;

  ltos_lrx_t r_r;
  ltos_lrx_t r_nxt;
  logic [7:0] d;
  logic [7:0] exp_id;
  logic       com;

  always_comb
  begin
    // Control symbols keep their code; only data bytes see the inversion
    d      = (rx_is_k || !r_r.pol) ? rx_data : ~rx_data;
    exp_id = r_r.is_ts2 ? ID_TS2 : ID_TS1;
    com    = rx_is_k && (rx_data == SYM_COM);
    r_nxt  = r_r;
    r_nxt.ts1_p = 1'b0;
    r_nxt.ts2_p = 1'b0;
    if (com)
    begin
      // COM restarts the walk, even inside a broken set
      r_nxt.in_set = 1'b1;
      r_nxt.idx    = IDX_LINK;
      r_nxt.bad    = 1'b0;
    end
    else if (r_r.in_set)
    begin
      r_nxt.idx = r_r.idx + 4'h1;
      case (r_r.idx)
        IDX_LINK:
        begin
          if (rx_is_k && rx_data == SYM_SKP)
            r_nxt.in_set = 1'b0;
          else if (rx_is_k && rx_data != SYM_PAD)
            r_nxt.bad = 1'b1;
          r_nxt.link     = d;
          r_nxt.link_pad = rx_is_k;
        end
        IDX_LANE:
        begin
          if (rx_is_k ? (rx_data != SYM_PAD) : (d > LANE_MAX))
            r_nxt.bad = 1'b1;
          r_nxt.lane = d;
        end
        IDX_NFTS:
        begin
          r_nxt.bad  = r_r.bad | rx_is_k;
          r_nxt.nfts = d;
        end
        IDX_RATE:
        begin
          r_nxt.bad  = r_r.bad | rx_is_k;
          r_nxt.rate = d;
        end
        IDX_CTRL:
        begin
          r_nxt.bad  = r_r.bad | rx_is_k;
          r_nxt.ctrl = d;
        end
        IDX_ID:
        begin
          if (rx_is_k)
            r_nxt.bad = 1'b1;
          else if (d == ID_TS1)
            r_nxt.is_ts2 = 1'b0;
          else if (d == ID_TS2)
            r_nxt.is_ts2 = 1'b1;
          else if (d == ID_TS1_INV)
          begin
            r_nxt.is_ts2 = 1'b0;
            r_nxt.pol    = 1'b1;
          end
          else if (d == ID_TS2_INV)
          begin
            r_nxt.is_ts2 = 1'b1;
            r_nxt.pol    = 1'b1;
          end
          else
            r_nxt.bad = 1'b1;
        end
        default:
        begin
          if (rx_is_k || d != exp_id)
            r_nxt.bad = 1'b1;
          if (r_r.idx == IDX_LAST)
          begin
            r_nxt.in_set = 1'b0;
            if (!r_r.bad && !rx_is_k && d == exp_id)
            begin
              r_nxt.ts1_p = !r_r.is_ts2;
              r_nxt.ts2_p = r_r.is_ts2;
              if (!r_r.is_ts2)
                r_nxt.compl = r_r.ctrl[CTRL_COMPL_BIT];
              else
                r_nxt.upcfg = r_r.rate[RATE_UPCFG_BIT];
              if (r_r.lock_cnt != LOCK_SETS)
                r_nxt.lock_cnt = r_r.lock_cnt + 4'h1;
              r_nxt.locked = (r_nxt.lock_cnt == LOCK_SETS);
            end
            else
            begin
              // A broken set drops symbol lock; polarity stays learned
              r_nxt.lock_cnt = 4'h0;
              r_nxt.locked   = 1'b0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  assign ts1_ok    = r_r.ts1_p;
  assign ts2_ok    = r_r.ts2_p;
  assign locked    = r_r.locked;
  assign rx_invert = r_r.pol;
  assign link_num  = r_r.link;
  assign link_pad  = r_r.link_pad;
  assign lane_num  = r_r.lane;
  assign nfts      = r_r.nfts;
  assign rate      = r_r.rate;
  assign compl_rx  = r_r.compl;
  assign upcfg     = r_r.upcfg;

  // ==========================================================
  // Checks
  a_pol_cause: assert property (@(posedge clk) disable iff (!nrst)
    $rose(r_r.pol) |-> $past(!rx_is_k && (rx_data == ID_TS1_INV || rx_data == ID_TS2_INV)))
    else $error("Polarity flipped without a complemented identifier");
  a_skp_drop: assert property (@(posedge clk) disable iff (!nrst)
    (r_r.in_set && r_r.idx == IDX_LINK && rx_is_k && rx_data == SYM_SKP) |=> !ts1_ok && !ts2_ok
      ##1 !ts1_ok && !ts2_ok)
    else $error("Skip set was taken as a training set");
  a_ts_pulse: assert property (@(posedge clk) disable iff (!nrst)
    (ts1_ok || ts2_ok) |-> $past(r_r.idx == IDX_LAST && r_r.in_set && !rx_is_k))
    else $error("Training set accepted away from its last symbol");
endmodule
`default_nettype wire

// ===== ltos_train.sv
/*
  Link training sequencer: detect, polling, configuration and working state,
  TS1/TS2 generation per lane, lock, width, rate, reversal and skew checks.
  Assumes transceivers report lane presence, deliver decoded symbols and
  accept one symbol per lane per clock; the data link layer reports active.
*/
`timescale 1ns/1ps
`default_nettype none
module ltos_train #(
  parameter int         LANES     = 4,
  parameter logic [7:0] LINK_NUM  = 8'h00,
  parameter logic [7:0] N_FTS     = 8'h20,
  parameter bit         GEN2      = 1'b1
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 cfg_done,
  input  wire logic [LANES-1:0]     rx_present,
  input  wire logic [LANES*8-1:0]   rx_data,
  input  wire logic [LANES-1:0]     rx_is_k,
  input  wire logic                 dl_active,
  output logic [LANES*8-1:0]        tx_data,
  output logic [LANES-1:0]          tx_is_k,
  output logic [LANES-1:0]          tx_elec_idle,
  output logic                      tx_os_bypass,
  output logic [LANES-1:0]          rx_invert,
  output ltos_pkg::ltos_state_t     ltssm_state,
  output logic [4:0]                link_width,
  output logic                      link_up,
  output logic                      link_gen2,
  output logic                      lane_reversed,
  output logic                      partner_compl_rx,
  output logic                      partner_upcfg,
  output logic [7:0]                partner_nfts
);
  import ltos_pkg::*;

  if (LANES < 1 || LANES > 16)
  begin : g_bad_lanes
    $error("LANES must be 1 to 16");
  end

  typedef struct packed {
    ltos_state_t          state;
    logic [3:0]           tx_idx;
    logic                 tx_ts2;
    logic [4:0]           tx_cnt;
    logic [4:0]           rx_cnt;
    logic [LANES-1:0]     active;
    logic                 deskew_ok;
    logic                 rev;
    logic                 gen2;
    logic                 link_up;
    logic                 bypass;
    logic [LANES*8-1:0]   txd;
    logic [LANES-1:0]     txk;
    logic [LANES-1:0]     eidle;
  } ltos_trn_t;

  ltos_trn_t r_r;
  ltos_trn_t r_nxt;

  logic [LANES-1:0]   ts1_ok;
  logic [LANES-1:0]   ts2_ok;
  logic [LANES-1:0]   locked;
  logic [LANES-1:0]   link_pad;
  logic [LANES-1:0]   compl_rx;
  logic [LANES-1:0]   upcfg;
  logic [LANES*8-1:0] link_num;
  logic [LANES*8-1:0] lane_num;
  logic [LANES*8-1:0] nfts;
  logic [LANES*8-1:0] rate;

  // ==========================================================
  // Helpers
  function automatic logic [4:0] popcount(input logic [LANES-1:0] v);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < LANES; i++)
      c = c + {4'h0, v[i]};
    return c;
  endfunction

  function automatic logic [4:0] sat_inc(input logic [4:0] v, input logic [4:0] lim);
    return (v >= lim) ? v : v + 5'h01;
  endfunction

  // Control flag in bit 8, symbol byte below
  function automatic logic [8:0] ts_sym(input logic [3:0] idx, input logic ts2,
                                        input logic cfg, input logic [7:0] lane);
    case (idx)
      IDX_COM:  ts_sym = {1'b1, SYM_COM};
      IDX_LINK: ts_sym = cfg ? {1'b0, LINK_NUM} : {1'b1, SYM_PAD};
      IDX_LANE: ts_sym = cfg ? {1'b0, lane} : {1'b1, SYM_PAD};
      IDX_NFTS: ts_sym = {1'b0, N_FTS};
      IDX_RATE: ts_sym = {1'b0, RATE_GEN1 | (GEN2 ? RATE_GEN2 : SYM_ZERO)};
      IDX_CTRL: ts_sym = {1'b0, SYM_ZERO};
      default:  ts_sym = {1'b0, ts2 ? ID_TS2 : ID_TS1};
    endcase
  endfunction

  // ==========================================================
  // Lane receivers
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    ltos_lane_rx u_rx (
      .clk       (clk),
      .nrst      (nrst),
      .rx_data   (rx_data[g*8 +: 8]),
      .rx_is_k   (rx_is_k[g]),
      .ts1_ok    (ts1_ok[g]),
      .ts2_ok    (ts2_ok[g]),
      .locked    (locked[g]),
      .rx_invert (rx_invert[g]),
      .link_num  (link_num[g*8 +: 8]),
      .link_pad  (link_pad[g]),
      .lane_num  (lane_num[g*8 +: 8]),
      .nfts      (nfts[g*8 +: 8]),
      .rate      (rate[g*8 +: 8]),
      .compl_rx  (compl_rx[g]),
      .upcfg     (upcfg[g])
    );
  end

  // ==========================================================
  // Sequencer
  logic             set_end;
  logic             all_locked;
  logic             any_ts1;
  logic             any_ts2;
  logic             any_cfg;
  logic             any_match;
  logic [LANES-1:0] ends;
  logic [4:0]       width;
  logic [8:0]       sym;

  always_comb
  begin
    set_end    = (r_r.tx_idx == IDX_LAST);
    ends       = (ts1_ok | ts2_ok) & r_r.active;
    all_locked = &(locked | ~r_r.active);
    any_ts1    = |(ts1_ok & r_r.active);
    any_ts2    = |(ts2_ok & r_r.active);
    any_cfg    = |(ends & ~link_pad);
    any_match  = |(ts2_ok & r_r.active & ~link_pad);
    width      = popcount(r_r.active);
    sym        = 9'h000;
    r_nxt      = r_r;
    r_nxt.tx_idx  = r_r.tx_idx + 4'h1;
    r_nxt.link_up = 1'b0;
    case (r_r.state)
      ST_DETECT:
      begin
        r_nxt.tx_ts2 = 1'b0;
        r_nxt.tx_cnt = 5'h00;
        r_nxt.rx_cnt = 5'h00;
        r_nxt.tx_idx = IDX_COM;
        if (cfg_done && |rx_present)
        begin
          r_nxt.active = rx_present;
          r_nxt.state  = ST_POLL;
        end
      end
      ST_POLL:
      begin
        if (!r_r.tx_ts2)
        begin
          if (any_ts1 || any_ts2)
            r_nxt.rx_cnt = sat_inc(r_r.rx_cnt, RX_NEED);
          if (all_locked && r_r.rx_cnt >= RX_NEED && set_end)
          begin
            r_nxt.tx_ts2 = 1'b1;
            r_nxt.rx_cnt = 5'h00;
            r_nxt.tx_cnt = 5'h00;
          end
        end
        else
        begin
          if (any_ts2)
            r_nxt.rx_cnt = sat_inc(r_r.rx_cnt, RX_NEED);
          if (set_end)
            r_nxt.tx_cnt = sat_inc(r_r.tx_cnt, TX_NEED);
          if (r_r.rx_cnt >= RX_NEED && r_r.tx_cnt >= TX_NEED && set_end)
          begin
            r_nxt.state  = ST_CONFIG;
            r_nxt.tx_ts2 = 1'b0;
            r_nxt.rx_cnt = 5'h00;
            r_nxt.tx_cnt = 5'h00;
          end
        end
      end
      ST_CONFIG:
      begin
        // Skew is judged by whether every active lane ends its set together
        if (|ends)
          r_nxt.deskew_ok = (ends == r_r.active);
        if (!r_r.tx_ts2)
        begin
          if (any_cfg)
            r_nxt.rx_cnt = sat_inc(r_r.rx_cnt, RX_NEED);
          if (r_r.rx_cnt >= RX_NEED && set_end)
          begin
            r_nxt.tx_ts2 = 1'b1;
            r_nxt.rx_cnt = 5'h00;
            r_nxt.tx_cnt = 5'h00;
          end
        end
        else
        begin
          if (any_match)
            r_nxt.rx_cnt = sat_inc(r_r.rx_cnt, RX_NEED);
          if (set_end)
            r_nxt.tx_cnt = sat_inc(r_r.tx_cnt, TX_NEED);
          if (r_r.rx_cnt >= RX_NEED && r_r.tx_cnt >= TX_NEED && set_end
              && r_r.deskew_ok)
          begin
            r_nxt.state = ST_L0;
            r_nxt.gen2  = GEN2 && rate[2];
            r_nxt.rev   = (width > 5'h01) &&
                          (lane_num[7:0] == {3'h0, width - 5'h01});
          end
        end
      end
      ST_L0:
      begin
        r_nxt.link_up = dl_active;
      end
      default:
      begin
        r_nxt.state = ST_DETECT;
      end
    endcase
    if (!cfg_done)
    begin
      r_nxt.state     = ST_DETECT;
      r_nxt.deskew_ok = 1'b0;
      r_nxt.link_up   = 1'b0;
    end
    // Ordered sets leave unscrambled; the bypass flag tells the scrambler
    r_nxt.bypass = (r_r.state == ST_POLL) || (r_r.state == ST_CONFIG);
    for (int i = 0; i < LANES; i++)
    begin
      sym = ts_sym(r_r.tx_idx, r_r.tx_ts2, r_r.state == ST_CONFIG, 8'(i));
      if (!r_nxt.bypass || !r_r.active[i])
        sym = 9'h000;
      r_nxt.txd[i*8 +: 8] = sym[7:0];
      r_nxt.txk[i]        = sym[8];
      r_nxt.eidle[i]      = (r_r.state == ST_DETECT) || !r_r.active[i];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r_r       <= '0;
      r_r.state <= ST_DETECT;
      r_r.eidle <= '1;
    end
    else
      r_r <= r_nxt;
  end

  assign tx_data          = r_r.txd;
  assign tx_is_k          = r_r.txk;
  assign tx_elec_idle     = r_r.eidle;
  assign tx_os_bypass     = r_r.bypass;
  assign ltssm_state      = r_r.state;
  assign link_width       = popcount(r_r.active);
  assign link_up          = r_r.link_up;
  assign link_gen2        = r_r.gen2;
  assign lane_reversed    = r_r.rev;
  assign partner_compl_rx = compl_rx[0];
  assign partner_upcfg    = upcfg[0];
  assign partner_nfts     = nfts[7:0];

  // ==========================================================
  // Checks
  logic tx_com0;
  logic tx_id0;
  assign tx_com0 = tx_is_k[0] && tx_data[7:0] == SYM_COM;
  assign tx_id0  = !tx_is_k[0] && (tx_data[7:0] == ID_TS1 || tx_data[7:0] == ID_TS2);

  sequence s_id_run;
    tx_id0 [*8] ##1 tx_id0;
  endsequence

  a_link_gate: assert property (@(posedge clk) disable iff (!nrst)
    link_up |-> ltssm_state == ST_L0 && $past(dl_active))
    else $error("Link up without data link active in L0");
  a_com_period: assert property (@(posedge clk) disable iff (!nrst || !cfg_done)
    tx_com0 |-> ##16 (tx_com0 || ltssm_state == ST_L0))
    else $error("Training set not sixteen symbols long");
  a_id_field: assert property (@(posedge clk) disable iff (!nrst || !cfg_done)
    (tx_com0 && ltssm_state != ST_L0) |-> ##6 s_id_run)
    else $error("Identifier symbols missing");
  a_idle_lanes: assert property (@(posedge clk) disable iff (!nrst)
    $rose(ltssm_state == ST_POLL) |=> tx_elec_idle == ~$past(rx_present, 2))
    else $error("Absent lane not held idle");
  a_poll_entry: assert property (@(posedge clk) disable iff (!nrst)
    $rose(ltssm_state == ST_POLL) |-> $past(ltssm_state) == ST_DETECT && $past(cfg_done))
    else $error("Polling entered without detect and configuration done");
  a_l0_entry: assert property (@(posedge clk) disable iff (!nrst)
    $rose(ltssm_state == ST_L0) |-> $past(ltssm_state) == ST_CONFIG && $past(r_r.deskew_ok))
    else $error("Working state entered without configuration and skew check");
  a_bypass_on: assert property (@(posedge clk) disable iff (!nrst || !cfg_done)
    (ltssm_state == ST_POLL && $past(ltssm_state) == ST_POLL) |-> tx_os_bypass)
    else $error("Ordered sets sent without scrambler bypass");
endmodule
`default_nettype wire

// ===== ltos_partner.sv
/*
  Link partner model: sends training sets that mirror what the device sends.
  Assumes lane 0 is present whenever the device trains.
*/
`timescale 1ns/1ps
`default_nettype none
module ltos_partner #(
  parameter int LANES = 2
) (
  input  wire logic               clk,
  input  wire logic [LANES*8-1:0] tx_data,
  input  wire logic [LANES-1:0]   tx_is_k,
  input  wire logic [LANES-1:0]   tx_elec_idle,
  input  wire logic [LANES-1:0]   inv,
  input  wire logic               skp,
  input  wire logic               rev,
  input  wire logic               skew,
  output logic      [LANES*8-1:0] rx_data,
  output logic      [LANES-1:0]   rx_is_k
);
  import ltos_pkg::*;
  // ==========================================================
  // Set position and mirrored fields
  logic [4:0] pi    = 5'h00;
  logic [4:0] dpos  = 5'h00;
  logic [7:0] did   = ID_TS1;
  logic [7:0] dlk   = SYM_PAD;
  logic       dlk_k = 1'b1;
  logic       dlnk  = 1'b1;
  logic [7:0] cyc   = 8'h00;
  logic [8:0] d1;
  logic [8:0] s;

  function automatic logic [8:0] sym(int i);
    logic [7:0] d;
    case (pi)
      5'd0: return {1'b1, SYM_COM};
      5'd1:
        if (dlk_k)
          return {1'b1, dlk};
        else
          d = dlk;
      5'd2:
        if (dlnk)
          return {1'b1, SYM_PAD};
        else
          d = 8'(rev ? LANES-1-i : i);
      5'd3: d = 8'h10;
      5'd4: d = (did == ID_TS2) ? 8'h46 : 8'h06;
      5'd5: d = (did == ID_TS2) ? 8'h10 : 8'h00;
      5'd16: return {1'b1, SYM_COM};
      5'd17, 5'd18, 5'd19: return {1'b1, SYM_SKP};
      default: d = did;
    endcase
    // Reversed polarity shows as complemented data bytes only
    return {1'b0, inv[i] ? ~d : d};
  endfunction

  always_ff @(posedge clk)
  begin
    cyc <= cyc + 8'h01;
    d1 <= sym(1);
    if (&tx_elec_idle)
    begin
      pi <= 5'h00;
      dpos <= 5'h00;
      did <= ID_TS1;
      dlk <= SYM_PAD;
      dlk_k <= 1'b1;
      dlnk <= 1'b1;
    end
    else
    begin
      pi <= ((pi == 5'd15 && !skp) || pi == 5'd19) ? 5'h00 : pi + 5'h01;
      dpos <= (tx_is_k[0] && tx_data[7:0] == SYM_COM) ? 5'h01 : dpos + 5'h01;
      if (dpos == 5'h01)
      begin
        dlk <= tx_data[7:0];
        dlk_k <= tx_is_k[0];
      end
      if (dpos == 5'h02)
        dlnk <= tx_is_k[0];
      if (dpos == 5'h06)
        did <= tx_data[7:0];
    end
  end

  // Released lanes show a changing pattern, never a held value
  always_comb
    for (int i = 0; i < LANES; i++)
    begin
      s = (skew && i == 1) ? d1 : sym(i);
      if (tx_elec_idle[i])
        s = {1'b0, cyc};
      rx_data[i*8 +: 8] = s[7:0];
      rx_is_k[i] = s[8];
    end
endmodule
`default_nettype wire

// ===== ltos_train_tb.sv
/*
  Self-checking bench for the training sequencer with two lanes.
  Assumes the partner model mirrors the device's training sets.
*/
`timescale 1ns/1ps
`default_nettype none
module ltos_train_tb;
  import ltos_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cfg_done = 1'b0;
  logic [1:0] rx_present = 2'b00;
  logic dl_active = 1'b0;
  logic [1:0] inv = 2'b00;
  logic skp = 1'b0;
  logic rev = 1'b0;
  logic skew = 1'b0;
  logic [15:0] rx_data, tx_data;
  logic [1:0] rx_is_k, tx_is_k, tx_elec_idle, rx_invert;
  logic tx_os_bypass, link_up, link_gen2, lane_reversed, partner_compl_rx, partner_upcfg;
  logic [4:0] link_width;
  logic [7:0] partner_nfts;
  ltos_state_t ltssm_state;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;

  initial forever #2.5 clk = ~clk;

  ltos_train #(.LANES(2)) dut (.clk(clk), .nrst(nrst), .cfg_done(cfg_done),
    .rx_present(rx_present), .rx_data(rx_data), .rx_is_k(rx_is_k),
    .dl_active(dl_active), .tx_data(tx_data), .tx_is_k(tx_is_k),
    .tx_elec_idle(tx_elec_idle), .tx_os_bypass(tx_os_bypass), .rx_invert(rx_invert),
    .ltssm_state(ltssm_state), .link_width(link_width), .link_up(link_up),
    .link_gen2(link_gen2), .lane_reversed(lane_reversed),
    .partner_compl_rx(partner_compl_rx), .partner_upcfg(partner_upcfg),
    .partner_nfts(partner_nfts));

  ltos_partner #(.LANES(2)) partner (.clk(clk), .tx_data(tx_data), .tx_is_k(tx_is_k),
    .tx_elec_idle(tx_elec_idle), .inv(inv), .skp(skp), .rev(rev), .skew(skew),
    .rx_data(rx_data), .rx_is_k(rx_is_k));

  // ==========================================================
  // Shared tasks
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic do_reset(logic [1:0] p, logic [1:0] iv, logic sk, logic rv, logic sw);
    @(negedge clk);
    nrst = 1'b0;
    cfg_done = 1'b0;
    dl_active = 1'b0;
    rx_present = p;
    inv = iv;
    skp = sk;
    rev = rv;
    skew = sw;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
  endtask

  task automatic wait_st(ltos_state_t st, int n);
    int k = 0;
    while (ltssm_state !== st && k < n)
    begin
      @(negedge clk);
      k++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    do_reset(2'b11, 2'b00, 1'b0, 1'b0, 1'b0);
    chk("state", ST_DETECT, ltssm_state);
    chk("eidle", 2'b11, tx_elec_idle);
    chk("link_up", 0, link_up);
    repeat (50) @(negedge clk);
    chk("hold", ST_DETECT, ltssm_state);
  endtask

  task automatic t_tx_order();
    logic [8:0] ex;
    int k = 0;
    do_reset(2'b01, 2'b00, 1'b0, 1'b0, 1'b0);
    cfg_done = 1'b1;
    wait_st(ST_POLL, 5);
    chk("poll", ST_POLL, ltssm_state);
    @(negedge clk);
    chk("bypass", 1, tx_os_bypass);
    chk("eidle", 2'b10, tx_elec_idle);
    while (!(tx_is_k[0] === 1'b1 && tx_data[7:0] === SYM_COM) && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    for (int i = 0; i < 16; i++)
    begin
      ex = i == 0 ? {1'b1, SYM_COM} : i < 3 ? {1'b1, SYM_PAD} : i == 3 ? 9'h020 :
           i == 4 ? 9'h006 : i == 5 ? 9'h000 : {1'b0, ID_TS1};
      chk("tx_sym", ex, {tx_is_k[0], tx_data[7:0]});
      chk("tx_lane1", 0, tx_data[15:8]);
      @(negedge clk);
    end
    wait_st(ST_L0, 3000);
    chk("l0", ST_L0, ltssm_state);
    chk("width", 1, link_width);
    chk("eidle_l0", 2'b10, tx_elec_idle);
  endtask

  task automatic t_full();
    int k = 0;
    do_reset(2'b11, 2'b10, 1'b1, 1'b1, 1'b0);
    cfg_done = 1'b1;
    wait_st(ST_CONFIG, 3000);
    chk("config", ST_CONFIG, ltssm_state);
    chk("invert", 2'b10, rx_invert);
    // Step past the last polling TS2 symbol still on the wire at entry
    @(negedge clk);
    while (!(tx_is_k[1] === 1'b0 && tx_data[15:8] === ID_TS2) && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    for (int i = 0; i < 9; i++)
    begin
      @(negedge clk);
      chk("ts2_id", ID_TS2, tx_data[15:8]);
    end
    wait_st(ST_L0, 3000);
    chk("l0", ST_L0, ltssm_state);
    chk("width", 2, link_width);
    chk("reversed", 1, lane_reversed);
    chk("gen2", 1, link_gen2);
    chk("nfts", 8'h10, partner_nfts);
    chk("compl", 0, partner_compl_rx);
    chk("upcfg", 1, partner_upcfg);
    repeat (5) @(negedge clk);
    chk("up_early", 0, link_up);
    dl_active = 1'b1;
    @(negedge clk);
    chk("up", 1, link_up);
    dl_active = 1'b0;
    @(negedge clk);
    chk("down", 0, link_up);
  endtask

  task automatic t_skew();
    do_reset(2'b11, 2'b00, 1'b0, 1'b0, 1'b1);
    cfg_done = 1'b1;
    repeat (3000) @(negedge clk);
    chk("skew_no_l0", 1, ltssm_state !== ST_L0);
    chk("skew_cfg", ST_CONFIG, ltssm_state);
  endtask

  // Ceiling covers four scenarios of at most a few thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  initial
  begin
    t_reset();
    t_tx_order();
    t_full();
    t_skew();
    report_and_stop();
  end
endmodule
`default_nettype wire
